// >>> design/rac_pkg.sv
// Purpose: shared constants for the radio address and checksum config bank
// Assumes: byte addresses on a 12-bit wishbone address, 32-bit data
// Notes: offsets are byte addresses of aligned words
package rac_pkg;
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [11:0] OFF_BASE_WORD_ZERO = 12'h51C;
    localparam logic [11:0] OFF_BASE_WORD_ONE = 12'h520;
    localparam logic [11:0] OFF_PFX_LO = 12'h524;
    localparam logic [11:0] OFF_PFX_HI = 12'h528;
    localparam logic [11:0] OFF_TXSEL = 12'h52C;
    localparam logic [11:0] OFF_RXEN = 12'h530;
    localparam logic [11:0] OFF_CRCCFG = 12'h534;
    localparam logic [11:0] OFF_POLY = 12'h538;
    localparam logic [11:0] OFF_SEED = 12'h53C;
    localparam logic [11:0] OFF_FMT = 12'h580;
    localparam logic [11:0] OFF_STAT = 12'h584;
    // ----------------------------------------
    // field layout
    // ----------------------------------------
    localparam int CRC_LEN_LSB = 0;
    localparam int CRC_SKIP_BIT = 8;
    localparam int POLY_CONST_BIT = 0;
    localparam int STAT_LEN_LSB = 4;
    localparam int STAT_CRC_BIT = 8;
    // ----------------------------------------
    // reset values and limits
    // ----------------------------------------
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [2:0] RST_TXSEL = 3'h0;
    localparam logic [7:0] RST_RXEN = 8'h00;
    localparam logic [1:0] RST_CRC_LEN = 2'h0;
    localparam logic [2:0] RST_BASE_BYTE_COUNT = 3'h4;
    localparam logic [2:0] BASE_BYTE_COUNT_MIN = 3'h2;
    localparam logic [2:0] BASE_BYTE_COUNT_MAX = 3'h4;
endpackage

// >>> design/rac_addr_build.sv
// Purpose: assemble one on-air address from a base word and a prefix byte
// Assumes: base length already held in a register of the caller
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module rac_addr_build (
    input wire logic [31:0] base,
    input wire logic [7:0] prefix,
    input wire logic [2:0] base_len,
    output logic [39:0] addr,
    output logic [2:0] addr_len
);
    logic [2:0] len_c;

    // ----------------------------------------
    // base bytes first, prefix byte right after
    // ----------------------------------------
    always_comb begin
        len_c = base_len;
        if (base_len < rac_pkg::BASE_BYTE_COUNT_MIN) begin
            len_c = rac_pkg::BASE_BYTE_COUNT_MIN;
        end else if (base_len > rac_pkg::BASE_BYTE_COUNT_MAX) begin
            len_c = rac_pkg::BASE_BYTE_COUNT_MAX;
        end
        addr_len = len_c + 3'h1;
        case (len_c)
            3'h2: addr = {16'h0000, prefix, base[15:0]};
            3'h3: addr = {8'h00, prefix, base[23:0]};
            default: addr = {prefix, base};
        endcase
    end
endmodule
`default_nettype wire

// >>> design/rac_config.sv
// Purpose: register bank for radio address and checksum settings
// Assumes: classic wishbone slave, one-cycle ack, one clock domain
// Notes: settings reach the packet engine one cycle after the write edge
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module rac_config (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [2:0] rx_query_index,
    output logic [39:0] tx_addr,
    output logic [2:0] tx_addr_len,
    output logic [39:0] rx_query_addr,
    output logic rx_query_enabled,
    output logic [7:0] rx_addr_enable,
    output logic checksum_enable,
    output logic [1:0] checksum_byte_count,
    output logic exclude_address_from_checksum,
    output logic [2:0] checksum_skip_bytes,
    output logic [31:0] checksum_polynomial,
    output logic [31:0] checksum_seed
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = din[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [7:0] pick_prefix(input logic [63:0] pfx, input logic [2:0] idx);
        return pfx[8*idx +: 8];
    endfunction

    function automatic logic [31:0] pick_base(input logic [31:0] b0, input logic [31:0] b1,
                                              input logic [2:0] idx);
        return (idx == 3'h0) ? b0 : b1;
    endfunction

    // ----------------------------------------
    // register state
    // ----------------------------------------
    logic [31:0] base_word_zero_reg, base_word_zero_next;
    logic [31:0] base_word_one_reg, base_word_one_next;
    logic [63:0] pfx_reg, pfx_next;
    logic [2:0] txsel_reg, txsel_next;
    logic [7:0] rxen_reg, rxen_next;
    logic [1:0] crclen_reg, crclen_next;
    logic skip_reg, skip_next;
    logic [31:0] poly_reg, poly_next;
    logic [31:0] seed_reg, seed_next;
    logic [2:0] base_byte_count_reg, base_byte_count_next;
    logic ack_reg, ack_next;
    logic [31:0] rdat_reg, rdat_next;
    logic wr_en;
    logic [31:0] wr_word;
    logic [31:0] rd_word;
    logic [11:0] word_adr;

    assign word_adr = {wb_adr_i[11:2], 2'b00};
    // a write lands on the edge where the master samples ack high
    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;

    always_comb begin
        wr_word = 32'h0000_0000;
        rd_word = 32'h0000_0000;
        if (word_adr == rac_pkg::OFF_BASE_WORD_ZERO) begin
            rd_word = base_word_zero_reg;
        end else if (word_adr == rac_pkg::OFF_BASE_WORD_ONE) begin
            rd_word = base_word_one_reg;
        end else if (word_adr == rac_pkg::OFF_PFX_LO) begin
            rd_word = pfx_reg[31:0];
        end else if (word_adr == rac_pkg::OFF_PFX_HI) begin
            rd_word = pfx_reg[63:32];
        end else if (word_adr == rac_pkg::OFF_TXSEL) begin
            rd_word = {29'h0, txsel_reg};
        end else if (word_adr == rac_pkg::OFF_RXEN) begin
            rd_word = {24'h0, rxen_reg};
        end else if (word_adr == rac_pkg::OFF_CRCCFG) begin
            rd_word[rac_pkg::CRC_LEN_LSB +: 2] = crclen_reg;
            rd_word[rac_pkg::CRC_SKIP_BIT] = skip_reg;
        end else if (word_adr == rac_pkg::OFF_POLY) begin
            rd_word = poly_reg;
        end else if (word_adr == rac_pkg::OFF_SEED) begin
            rd_word = seed_reg;
        end else if (word_adr == rac_pkg::OFF_FMT) begin
            rd_word = {29'h0, base_byte_count_reg};
        end else if (word_adr == rac_pkg::OFF_STAT) begin
            rd_word[2:0] = tx_addr_len;
            rd_word[rac_pkg::STAT_LEN_LSB +: 3] = checksum_skip_bytes;
            rd_word[rac_pkg::STAT_CRC_BIT] = checksum_enable;
        end
        wr_word = merge(rd_word, wb_dat_i, wb_sel_i);
    end

    // ----------------------------------------
    // register writes and bus answer
    // ----------------------------------------
    always_comb begin
        base_word_zero_next = base_word_zero_reg;
        base_word_one_next = base_word_one_reg;
        pfx_next = pfx_reg;
        txsel_next = txsel_reg;
        rxen_next = rxen_reg;
        crclen_next = crclen_reg;
        skip_next = skip_reg;
        poly_next = poly_reg;
        seed_next = seed_reg;
        base_byte_count_next = base_byte_count_reg;
        ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
        rdat_next = ack_next ? rd_word : 32'h0000_0000;
        if (wr_en) begin
            if (word_adr == rac_pkg::OFF_BASE_WORD_ZERO) begin
                base_word_zero_next = wr_word;
            end else if (word_adr == rac_pkg::OFF_BASE_WORD_ONE) begin
                base_word_one_next = wr_word;
            end else if (word_adr == rac_pkg::OFF_PFX_LO) begin
                pfx_next[31:0] = wr_word;
            end else if (word_adr == rac_pkg::OFF_PFX_HI) begin
                pfx_next[63:32] = wr_word;
            end else if (word_adr == rac_pkg::OFF_TXSEL) begin
                txsel_next = wr_word[2:0];
            end else if (word_adr == rac_pkg::OFF_RXEN) begin
                rxen_next = wr_word[7:0];
            end else if (word_adr == rac_pkg::OFF_CRCCFG) begin
                crclen_next = wr_word[rac_pkg::CRC_LEN_LSB +: 2];
                skip_next = wr_word[rac_pkg::CRC_SKIP_BIT];
            end else if (word_adr == rac_pkg::OFF_POLY) begin
                poly_next = wr_word;
            end else if (word_adr == rac_pkg::OFF_SEED) begin
                seed_next = wr_word;
            end else if (word_adr == rac_pkg::OFF_FMT) begin
                base_byte_count_next = wr_word[2:0];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            base_word_zero_reg <= rac_pkg::RST_WORD;
            base_word_one_reg <= rac_pkg::RST_WORD;
            pfx_reg <= {rac_pkg::RST_WORD, rac_pkg::RST_WORD};
            txsel_reg <= rac_pkg::RST_TXSEL;
            rxen_reg <= rac_pkg::RST_RXEN;
            crclen_reg <= rac_pkg::RST_CRC_LEN;
            skip_reg <= 1'b0;
            poly_reg <= rac_pkg::RST_WORD;
            seed_reg <= rac_pkg::RST_WORD;
            base_byte_count_reg <= rac_pkg::RST_BASE_BYTE_COUNT;
            ack_reg <= 1'b0;
            rdat_reg <= rac_pkg::RST_WORD;
        end else begin
            base_word_zero_reg <= base_word_zero_next;
            base_word_one_reg <= base_word_one_next;
            pfx_reg <= pfx_next;
            txsel_reg <= txsel_next;
            rxen_reg <= rxen_next;
            crclen_reg <= crclen_next;
            skip_reg <= skip_next;
            poly_reg <= poly_next;
            seed_reg <= seed_next;
            base_byte_count_reg <= base_byte_count_next;
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;

    // ----------------------------------------
    // address assembly for transmit and receive lookup
    // ----------------------------------------
    logic [39:0] tx_addr_c, rxq_addr_c;
    logic [2:0] tx_len_c;

    rac_addr_build u_tx_build (
        .base(pick_base(base_word_zero_reg, base_word_one_reg, txsel_reg)),
        .prefix(pick_prefix(pfx_reg, txsel_reg)),
        .base_len(base_byte_count_reg),
        .addr(tx_addr_c),
        .addr_len(tx_len_c)
    );

    rac_addr_build u_rx_build (
        .base(pick_base(base_word_zero_reg, base_word_one_reg, rx_query_index)),
        .prefix(pick_prefix(pfx_reg, rx_query_index)),
        .base_len(base_byte_count_reg),
        .addr(rxq_addr_c),
        .addr_len()
    );

    // ----------------------------------------
    // registered settings toward the packet engine
    // ----------------------------------------
    logic [39:0] txa_reg, txa_next, rxqa_reg, rxqa_next;
    logic [2:0] txl_reg, txl_next, skipb_reg, skipb_next;
    logic rxqe_reg, rxqe_next, crcen_reg, crcen_next, excl_reg, excl_next;
    logic [7:0] rxe_reg, rxe_next;
    logic [1:0] crcb_reg, crcb_next;
    logic [31:0] polo_reg, polo_next, seedo_reg, seedo_next;

    always_comb begin
        txa_next = tx_addr_c;
        txl_next = tx_len_c;
        rxqa_next = rxq_addr_c;
        rxqe_next = rxen_reg[rx_query_index];
        rxe_next = rxen_reg;
        crcen_next = (crclen_reg != 2'h0);
        crcb_next = crclen_reg;
        excl_next = skip_reg && crcen_next;
        skipb_next = excl_next ? tx_len_c : 3'h0;
        polo_next = poly_reg;
        polo_next[rac_pkg::POLY_CONST_BIT] = 1'b1;
        seedo_next = seed_reg;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            txa_reg <= 40'h00_0000_0000;
            txl_reg <= 3'h0;
            rxqa_reg <= 40'h00_0000_0000;
            rxqe_reg <= 1'b0;
            rxe_reg <= rac_pkg::RST_RXEN;
            crcen_reg <= 1'b0;
            crcb_reg <= rac_pkg::RST_CRC_LEN;
            excl_reg <= 1'b0;
            skipb_reg <= 3'h0;
            polo_reg <= rac_pkg::RST_WORD;
            seedo_reg <= rac_pkg::RST_WORD;
        end else begin
            txa_reg <= txa_next;
            txl_reg <= txl_next;
            rxqa_reg <= rxqa_next;
            rxqe_reg <= rxqe_next;
            rxe_reg <= rxe_next;
            crcen_reg <= crcen_next;
            crcb_reg <= crcb_next;
            excl_reg <= excl_next;
            skipb_reg <= skipb_next;
            polo_reg <= polo_next;
            seedo_reg <= seedo_next;
        end
    end

    assign tx_addr = txa_reg;
    assign tx_addr_len = txl_reg;
    assign rx_query_addr = rxqa_reg;
    assign rx_query_enabled = rxqe_reg;
    assign rx_addr_enable = rxe_reg;
    assign checksum_enable = crcen_reg;
    assign checksum_byte_count = crcb_reg;
    assign exclude_address_from_checksum = excl_reg;
    assign checksum_skip_bytes = skipb_reg;
    assign checksum_polynomial = polo_reg;
    assign checksum_seed = seedo_reg;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_wr(logic [11:0] off);
        wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i == 4'hF && word_adr == off;
    endsequence

    property p_base_word_zero;
        s_wr(rac_pkg::OFF_BASE_WORD_ZERO) |=> base_word_zero_reg == $past(wb_dat_i);
    endproperty
    a_base_word_zero: assert property (p_base_word_zero) else $error("base word zero write lost");

    property p_base_word_one;
        s_wr(rac_pkg::OFF_BASE_WORD_ONE) |=> base_word_one_reg == $past(wb_dat_i);
    endproperty
    a_base_word_one: assert property (p_base_word_one) else $error("base word one write lost");

    property p_pfx_lo;
        s_wr(rac_pkg::OFF_PFX_LO) |=> pfx_reg[31:0] == $past(wb_dat_i);
    endproperty
    a_pfx_lo: assert property (p_pfx_lo) else $error("low prefix write lost");

    property p_pfx_hi;
        s_wr(rac_pkg::OFF_PFX_HI) |=> pfx_reg[63:32] == $past(wb_dat_i);
    endproperty
    a_pfx_hi: assert property (p_pfx_hi) else $error("high prefix write lost");

    property p_tx_prefix;
        rst_n ##1 ($stable(pfx_reg) && $stable(txsel_reg)) |->
            tx_addr[8*tx_addr_len-8 +: 8] == pfx_reg[8*txsel_reg +: 8];
    endproperty
    a_tx_prefix: assert property (p_tx_prefix) else $error("tx prefix not selected");

    property p_rx_enable;
        s_wr(rac_pkg::OFF_RXEN) |=> ##1 rx_addr_enable == $past(wb_dat_i[7:0], 2);
    endproperty
    a_rx_enable: assert property (p_rx_enable) else $error("rx enables wrong");

    property p_crc_off;
        crclen_reg == 2'h0 |=> !checksum_enable && checksum_skip_bytes == 3'h0;
    endproperty
    a_crc_off: assert property (p_crc_off) else $error("checksum not disabled");

    property p_crc_on;
        crclen_reg != 2'h0 |=> checksum_enable && checksum_byte_count == $past(crclen_reg);
    endproperty
    a_crc_on: assert property (p_crc_on) else $error("checksum length wrong");

    property p_skip;
        crclen_reg != 2'h0 && skip_reg |=> checksum_skip_bytes == $past(tx_len_c);
    endproperty
    a_skip: assert property (p_skip) else $error("address not excluded");

    property p_noskip;
        !skip_reg |=> !exclude_address_from_checksum && checksum_skip_bytes == 3'h0;
    endproperty
    a_noskip: assert property (p_noskip) else $error("address wrongly excluded");

    property p_poly;
        rst_n |=> checksum_polynomial == {$past(poly_reg[31:1]), 1'b1};
    endproperty
    a_poly: assert property (p_poly) else $error("polynomial output wrong");

    property p_len;
        rst_n |=> tx_addr_len >= 3'h3 && tx_addr_len <= 3'h5;
    endproperty
    a_len: assert property (p_len) else $error("address length out of range");

    property p_seed;
        s_wr(rac_pkg::OFF_SEED) |=> ##1 checksum_seed == $past(wb_dat_i, 2);
    endproperty
    a_seed: assert property (p_seed) else $error("seed not forwarded");

    property p_ack;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack held two cycles");
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// Purpose: self-checking bench for the radio address and checksum config bank
// Assumes: one-cycle wishbone ack, settings follow one edge after the write edge
// Notes: bus driven and answered on rising edges, settings sampled on falling edges
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic mclk;
    logic rst_n;
    logic wb_cyc_i;
    logic wb_stb_i;
    logic wb_we_i;
    logic [11:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [2:0] rx_query_index;
    logic [39:0] tx_addr;
    logic [2:0] tx_addr_len;
    logic [39:0] rx_query_addr;
    logic rx_query_enabled;
    logic [7:0] rx_addr_enable;
    logic checksum_enable;
    logic [1:0] checksum_byte_count;
    logic exclude_address_from_checksum;
    logic [2:0] checksum_skip_bytes;
    logic [31:0] checksum_polynomial;
    logic [31:0] checksum_seed;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    logic [31:0] b0 = 32'hA1B2C3D4;
    logic [31:0] b1 = 32'h5E6F7081;
    logic [31:0] p_lo = 32'h44332211;
    logic [31:0] p_hi = 32'h88776655;

    rac_config dut_u (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_query_index(rx_query_index),
        .tx_addr(tx_addr), .tx_addr_len(tx_addr_len), .rx_query_addr(rx_query_addr),
        .rx_query_enabled(rx_query_enabled), .rx_addr_enable(rx_addr_enable),
        .checksum_enable(checksum_enable), .checksum_byte_count(checksum_byte_count),
        .exclude_address_from_checksum(exclude_address_from_checksum),
        .checksum_skip_bytes(checksum_skip_bytes),
        .checksum_polynomial(checksum_polynomial), .checksum_seed(checksum_seed));

    // ----------------------------------------
    // clock, timeout and verdict
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            end_sim();
        end
    end

    // ----------------------------------------
    // bus and compare helpers
    // ----------------------------------------
    task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
        checked = checked + 1;
        if (got !== exp) begin
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
            miscompares = miscompares + 1;
        end
    endtask

    // holds the request until ack is sampled high, takes data and releases at that edge
    task automatic wb_xfer(input logic we, input logic [11:0] adr, input logic [3:0] sel,
                           input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= d;
        @(posedge mclk);
        while (wb_ack_o !== 1'b1) begin
            @(posedge mclk);
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] adr, input logic [31:0] d);
        logic [31:0] q;
        wb_xfer(1'b1, adr, 4'hF, d, q);
        repeat (2) @(negedge mclk);
    endtask

    task automatic rd_chk(input logic [11:0] adr, input logic [31:0] exp, input string what);
        logic [31:0] q;
        wb_xfer(1'b0, adr, 4'hF, 32'h0000_0000, q);
        chk({8'h00, q}, {8'h00, exp}, what);
    endtask

    function automatic logic [39:0] exp_addr(input int i);
        logic [7:0] p;
        p = (i < 4) ? p_lo[8*i +: 8] : p_hi[8*(i-4) +: 8];
        return {p, (i == 0) ? b0 : b1};
    endfunction

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk({8'h00, checksum_polynomial}, 40'h1, "poly bit0 after reset");
        chk({37'h0, tx_addr_len}, 40'h5, "addr len after reset");
        chk({32'h0, rx_addr_enable}, 40'h0, "rx enables after reset");
        chk({39'h0, checksum_enable}, 40'h0, "checksum off after reset");
        rd_chk(rac_pkg::OFF_BASE_WORD_ZERO, 32'h0000_0000, "base_word_zero reset");
        rd_chk(rac_pkg::OFF_BASE_WORD_ONE, 32'h0000_0000, "base_word_one reset");
        rd_chk(rac_pkg::OFF_PFX_HI, 32'h0000_0000, "prefix high reset");
        rd_chk(rac_pkg::OFF_RXEN, 32'h0000_0000, "rx enable reset");
        rd_chk(rac_pkg::OFF_CRCCFG, 32'h0000_0000, "crc cfg reset");
        rd_chk(rac_pkg::OFF_POLY, 32'h0000_0000, "poly reset");
    endtask

    task automatic t_words();
        logic [31:0] q;
        wb_xfer(1'b1, rac_pkg::OFF_BASE_WORD_ZERO, 4'h2, 32'hFFFF_FFFF, q);
        rd_chk(rac_pkg::OFF_BASE_WORD_ZERO, 32'h0000_FF00, "base_word_zero byte enable");
        wr(rac_pkg::OFF_BASE_WORD_ZERO, b0);
        wr(rac_pkg::OFF_BASE_WORD_ONE, b1);
        wr(rac_pkg::OFF_PFX_LO, p_lo);
        wr(rac_pkg::OFF_PFX_HI, p_hi);
        wr(12'h540, 32'h1234_5678);
        rd_chk(rac_pkg::OFF_BASE_WORD_ZERO, b0, "base_word_zero readback");
        rd_chk(rac_pkg::OFF_BASE_WORD_ONE, b1, "base_word_one readback");
        rd_chk(rac_pkg::OFF_PFX_LO, p_lo, "prefix low readback");
        rd_chk(rac_pkg::OFF_PFX_HI, p_hi, "prefix high readback");
        rd_chk(12'h540, 32'h0000_0000, "unmapped read");
    endtask

    task automatic t_tx_select();
        for (int i = 0; i < 8; i++) begin
            wr(rac_pkg::OFF_TXSEL, i);
            chk(tx_addr, exp_addr(i), "tx address for select");
        end
        wr(rac_pkg::OFF_FMT, 32'h0000_0003);
        chk({37'h0, tx_addr_len}, 40'h4, "addr len three base bytes");
        chk({8'h00, tx_addr[31:0]}, {8'h00, p_hi[31:24], b1[23:0]}, "three byte addr");
        wr(rac_pkg::OFF_FMT, 32'h0000_0001);
        chk({37'h0, tx_addr_len}, 40'h3, "addr len clamped low");
        chk(tx_addr, {16'h0000, p_hi[31:24], b1[15:0]}, "two byte addr");
        wr(rac_pkg::OFF_FMT, 32'h0000_0007);
        chk({37'h0, tx_addr_len}, 40'h5, "addr len clamped high");
        wr(rac_pkg::OFF_FMT, 32'h0000_0004);
    endtask

    task automatic t_rx_enable();
        logic [7:0] en;
        en = 8'hA5;
        wr(rac_pkg::OFF_RXEN, {24'h00_0000, en});
        chk({32'h0, rx_addr_enable}, {32'h0, en}, "rx enable bits");
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk);
            rx_query_index <= 3'(i);
            @(posedge mclk);
            @(negedge mclk);
            chk({39'h0, rx_query_enabled}, {39'h0, en[i]}, "rx enable of index");
            chk(rx_query_addr, exp_addr(i), "rx address of index");
        end
    endtask

    task automatic t_crc_cfg();
        logic on;
        for (int l = 0; l < 4; l++) begin
            for (int s = 0; s < 2; s++) begin
                on = (l != 0);
                wr(rac_pkg::OFF_CRCCFG, (s << 8) | l);
                chk({39'h0, checksum_enable}, {39'h0, on}, "checksum enable");
                chk({38'h0, checksum_byte_count}, l, "checksum bytes");
                chk({39'h0, exclude_address_from_checksum}, on && s, "exclude addr");
                chk({37'h0, checksum_skip_bytes}, (on && s) ? 5 : 0, "skip bytes");
                rd_chk(rac_pkg::OFF_CRCCFG, (s << 8) | l, "crc cfg readback");
            end
        end
        rd_chk(rac_pkg::OFF_STAT, 32'h0000_0155, "status word");
    endtask

    task automatic t_poly_seed();
        wr(rac_pkg::OFF_POLY, 32'h0000_018C);
        chk({8'h00, checksum_polynomial}, 40'h18D, "poly constant term");
        rd_chk(rac_pkg::OFF_POLY, 32'h0000_018C, "poly readback");
        wr(rac_pkg::OFF_POLY, 32'h0000_0003);
        chk({8'h00, checksum_polynomial}, 40'h3, "poly x term");
        wr(rac_pkg::OFF_SEED, 32'hC0FF_EE55);
        chk({8'h00, checksum_seed}, 40'hC0FFEE55, "seed output");
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 12'h000;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0000_0000;
        rx_query_index = 3'h0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(negedge mclk);
        t_reset();
        t_words();
        t_tx_select();
        t_rx_enable();
        t_crc_cfg();
        t_poly_seed();
        end_sim();
    end
endmodule
`default_nettype wire
